// ---- hw/shu_shift_unit.sv ----
// Behaviour
// [RULE_01] Register count from amount operand low five
// [RULE_02] Immediate count from instruction bits 16-20
// [RULE_03] Left: rotate N, mask ones then zeros
// [RULE_04] Right: rotate left by 32-N
// [RULE_05] Right mask: N zeros then ones
// [RULE_06] Plain forms: bit 26 gives zero mask
// [RULE_07] Non-merging: destination is rotated AND mask
// [RULE_08] Non-merging extension forms load rotated word
// [RULE_09] Long immediate merges rotated with extension
// [RULE_10] Long immediate loads rotated, merges old value
// [RULE_11] Long register, bit 26 clear: normal merge
// [RULE_12] Long left, bit 26: tail mask, zeros
// [RULE_13] Long right, bit 26: head ones, zeros
// [RULE_14] Long register forms keep extension register
// [RULE_15] Record flag gates condition field update
// [RULE_16] Exception register never modified here
// [RULE_17] Merge: mask one picks word, zero extension
// [RULE_18] Flags compare destination signed with zero
// [RULE_19] Overflow, summary and carry left alone
// [RULE_20] Summary bit copies exception register bit
// [RULE_21] All results from one issue cycle

`timescale 1ns/10ps
`default_nettype none

`include "shu_defines.svh"

module shu_shift_unit
(
    input  wire logic              mclk_in,
    input  wire logic              resetn_in,
    input  wire logic              issue_valid_in,
    input  var  shu_pkg::shu_req_t req_in,
    input  var  shu_pkg::shu_xer_t xer_in,
    input  wire logic              ext_write_in,
    input  wire logic [31:0]       ext_wdata_in,
    output logic                   dest_valid_out,
    output logic [31:0]            dest_word_out,
    output logic [31:0]            extension_register_out,
    output var  shu_pkg::shu_cr0_t condition_register_out,
    output var  shu_pkg::shu_xer_t xer_out,
    output logic                   op_error_out
);

    // ************************************************************
    // Operation decode
    // ************************************************************

    logic                  is_right;
    logic                  use_imm;
    logic                  big_amt;
    logic                  legal_op;
    logic                  loads_ext;
    logic                  merges;
    logic                  long_reg;
    logic [`SHU_CNT_MSB:0] count;

    always_comb
    begin
        is_right  = 1'b0;
        use_imm   = 1'b0;
        loads_ext = 1'b0;
        merges    = 1'b0;
        long_reg  = 1'b0;
        legal_op  = 1'b1;
        unique case (req_in.op)
            shu_pkg::SHU_OP_LEFT:
            begin
                is_right = 1'b0;
            end
            shu_pkg::SHU_OP_RIGHT:
            begin
                is_right = 1'b1;
            end
            shu_pkg::SHU_OP_SLQ:
            begin
                loads_ext = 1'b1;
            end
            shu_pkg::SHU_OP_SRQ:
            begin
                is_right  = 1'b1;
                loads_ext = 1'b1;
            end
            shu_pkg::SHU_OP_SLIQ:
            begin
                use_imm   = 1'b1;
                loads_ext = 1'b1;
            end
            shu_pkg::SHU_OP_SRIQ:
            begin
                is_right  = 1'b1;
                use_imm   = 1'b1;
                loads_ext = 1'b1;
            end
            shu_pkg::SHU_OP_SLLIQ:
            begin
                use_imm   = 1'b1;
                loads_ext = 1'b1;
                merges    = 1'b1;
            end
            shu_pkg::SHU_OP_SRLIQ:
            begin
                is_right  = 1'b1;
                use_imm   = 1'b1;
                loads_ext = 1'b1;
                merges    = 1'b1;
            end
            shu_pkg::SHU_OP_SLLQ:
            begin
                merges   = 1'b1;
                long_reg = 1'b1;
            end
            shu_pkg::SHU_OP_SRLQ:
            begin
                is_right = 1'b1;
                merges   = 1'b1;
                long_reg = 1'b1;
            end
            // Codes 10..15 are not shift operations of this unit
            default:
            begin
                legal_op = 1'b0;
            end
        endcase
    end

    // Immediate forms ignore bit 26 entirely
    assign big_amt = req_in.amount_operand[`SHU_AMT_BIG] & ~use_imm;

    // [RULE_01] [RULE_02] Count source select
    assign count = use_imm ? req_in.instr_word[`SHU_IMM_HI:`SHU_IMM_LO]
                           : req_in.amount_operand[`SHU_AMT_HI:`SHU_AMT_LO];

    // ************************************************************
    // Rotate and mask
    // ************************************************************

    logic [31:0] rotated;
    logic [31:0] head_mask;
    logic [31:0] tail_mask;

    // [RULE_03] [RULE_04] [RULE_05] Rotator and masks
    shu_rot_mask u_rot_mask
    (
        .word_in       (req_in.source_word),
        .count_in      (count),
        .right_in      (is_right),
        .rotated_out   (rotated),
        .head_mask_out (head_mask),
        .tail_mask_out (tail_mask)
    );

    // ************************************************************
    // Result forming
    // ************************************************************

    logic [31:0] mask;
    logic [31:0] data_word;
    logic [31:0] result;

    always_comb
    begin
        mask      = head_mask;
        data_word = rotated;
        if (long_reg && big_amt)
        begin
            // [RULE_12] [RULE_13] Bit 26 long shapes
            mask      = tail_mask;
            data_word = `SHU_ZERO;
        end
        else if (!merges && big_amt)
        begin
            // [RULE_06] All-zero mask
            mask = `SHU_ZERO;
        end
        // [RULE_09] [RULE_11] [RULE_17] Merge against old extension value
        if (merges)
        begin
            result = (data_word & mask) | (extension_register_out & ~mask);
        end
        else
        begin
            // [RULE_07] Masked rotate
            result = data_word & mask;
        end
    end

    // ************************************************************
    // Condition flags
    // ************************************************************

    shu_pkg::shu_cr0_t cr0_calc;

    always_comb
    begin
        // [RULE_18] Signed compare with zero
        cr0_calc.less_flag    = result[`SHU_MSB];
        cr0_calc.equal_flag   = (result == `SHU_ZERO);
        cr0_calc.greater_flag = ~result[`SHU_MSB] & (result != `SHU_ZERO);
        // [RULE_20] Summary copied from exception register
        cr0_calc.summary_ovf  = xer_in.summary_ovf;
    end

    // ************************************************************
    // State registers
    // ************************************************************

    logic              valid_d;
    logic              valid_q;
    logic              err_d;
    logic              err_q;
    logic [31:0]       dest_d;
    logic [31:0]       dest_q;
    shu_pkg::shu_cr0_t cond_d;
    shu_pkg::shu_cr0_t cond_q;
    shu_pkg::shu_xer_t xer_d;
    shu_pkg::shu_xer_t xer_q;

    logic fire;

    // An illegal code is refused as a shift only; a side write in that
    // cycle still lands in the extension register
    assign fire = issue_valid_in & legal_op;

    always_comb
    begin
        // [RULE_21] Every result captured on the issue edge
        valid_d = fire;
        err_d   = issue_valid_in & ~legal_op;
        dest_d  = fire ? result : dest_q;
        cond_d  = cond_q;
        // [RULE_16] [RULE_19] Exception bits pass through untouched
        xer_d   = xer_in;
        // [RULE_15] Record flag gate
        if (fire && req_in.record_flag)
        begin
            cond_d = cr0_calc;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            valid_q <= 1'b0;
            err_q   <= 1'b0;
            dest_q  <= `SHU_DEST_RST;
            cond_q  <= '0;
            xer_q   <= '0;
        end
        else
        begin
            valid_q <= valid_d;
            err_q   <= err_d;
            dest_q  <= dest_d;
            cond_q  <= cond_d;
            xer_q   <= xer_d;
        end
    end

    // ************************************************************
    // Extension register
    // ************************************************************

    logic [31:0] ext_d;
    logic [31:0] ext_q;

    // One register, three writers: reset, the side move and a loading shift
    always_comb
    begin
        ext_d = ext_q;
        // Side write is for moves into the extension register; a loading shift wins
        if (ext_write_in)
        begin
            ext_d = ext_wdata_in;
        end
        // [RULE_08] [RULE_10] [RULE_14] Extension load on SLQ, SRQ and the four immediate forms
        if (fire && loads_ext)
        begin
            ext_d = rotated;
        end
    end

    // Merges read this register, not ext_d, so a merge issued right after a
    // loading shift takes the word that the earlier shift left here
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ext_q <= `SHU_EXT_RST;
        end
        else
        begin
            ext_q <= ext_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    assign dest_valid_out         = valid_q;
    assign op_error_out           = err_q;
    assign dest_word_out          = dest_q;
    assign extension_register_out = ext_q;
    assign condition_register_out = cond_q;
    assign xer_out                = xer_q;

endmodule

`default_nettype wire

// ---- hw/shu_defines.svh ----
`ifndef SHU_DEFINES_SVH
`define SHU_DEFINES_SVH

// Data path width and the top bit index of a word
`define SHU_W          32
`define SHU_MSB        31

// Word width held in a count one bit wider than the shift count
`define SHU_ROT_SPAN   6'h20

// Shift count field width and its top bit
`define SHU_CW         5
`define SHU_CNT_MSB    4

// Count N in the amount operand, big-endian bits 27..31
`define SHU_AMT_HI     4
`define SHU_AMT_LO     0

// Amount operand big-endian bit 26
`define SHU_AMT_BIG    5

// Immediate count, instruction big-endian bits 16..20
`define SHU_IMM_HI     15
`define SHU_IMM_LO     11

// Word constants
`define SHU_ZERO       32'h0000_0000
`define SHU_ONES       32'hffff_ffff

// Reset values
`define SHU_EXT_RST    32'h0000_0000
`define SHU_DEST_RST   32'h0000_0000

`endif

// ---- hw/shu_pkg.sv ----
`default_nettype none

package shu_pkg;

    // Operation selection supplied by decode
    typedef enum logic [3:0] {
        SHU_OP_LEFT  = 4'h0,
        SHU_OP_RIGHT = 4'h1,
        SHU_OP_SLQ   = 4'h2,
        SHU_OP_SRQ   = 4'h3,
        SHU_OP_SLIQ  = 4'h4,
        SHU_OP_SRIQ  = 4'h5,
        SHU_OP_SLLIQ = 4'h6,
        SHU_OP_SRLIQ = 4'h7,
        SHU_OP_SLLQ  = 4'h8,
        SHU_OP_SRLQ  = 4'h9
    } shu_op_t;

    // Condition field 0
    typedef struct packed {
        logic less_flag;
        logic greater_flag;
        logic equal_flag;
        logic summary_ovf;
    } shu_cr0_t;

    // Fixed-point exception register bits seen by this unit
    typedef struct packed {
        logic summary_ovf;
        logic overflow_flag;
        logic carry_flag;
    } shu_xer_t;

    // Issue bundle from decode
    typedef struct packed {
        shu_op_t     op;
        logic [31:0] source_word;
        logic [31:0] amount_operand;
        logic [31:0] instr_word;
        logic        record_flag;
    } shu_req_t;

endpackage

`default_nettype wire

// ---- hw/shu_rot_mask.sv ----
`timescale 1ns/10ps
`default_nettype none

`include "shu_defines.svh"

// Rotator plus the two mask shapes used by the shift unit
module shu_rot_mask
(
    input  wire logic [`SHU_MSB:0]     word_in,
    input  wire logic [`SHU_CNT_MSB:0] count_in,
    input  wire logic                  right_in,
    output logic      [`SHU_MSB:0]     rotated_out,
    output logic      [`SHU_MSB:0]     head_mask_out,
    output logic      [`SHU_MSB:0]     tail_mask_out
);

    logic [`SHU_MSB:0]     rot_left;
    logic [`SHU_MSB:0]     rot_right;
    logic [`SHU_MSB:0]     ones_shl;
    logic [`SHU_MSB:0]     ones_shr;

    // Left by 32-N is the same as right by N, and N = 0 is identity
    assign rot_left  = (word_in << count_in) | (word_in >> (`SHU_ROT_SPAN - {1'b0, count_in}));
    assign rot_right = (word_in >> count_in) | (word_in << (`SHU_ROT_SPAN - {1'b0, count_in}));
    assign rotated_out = right_in ? rot_right : rot_left;

    assign ones_shl = `SHU_ONES << count_in;
    assign ones_shr = `SHU_ONES >> count_in;

    // Left: 32-N ones then N zeros; right: N zeros then 32-N ones
    assign head_mask_out = right_in ? ones_shr : ones_shl;

    // Left: 32-N zeros then N ones; right: N ones then 32-N zeros
    assign tail_mask_out = right_in ? ~ones_shr : ~ones_shl;

endmodule

`default_nettype wire

// ---- verif/shu_shift_unit_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************
// Port checks
// ****************
module shu_checker
(
    input wire logic              mclk_in,
    input wire logic              resetn_in,
    input wire logic              issue_valid_in,
    input var  shu_pkg::shu_req_t req_in,
    input var  shu_pkg::shu_xer_t xer_in,
    input wire logic              ext_write_in,
    input wire logic [31:0]       ext_wdata_in,
    input wire logic              dest_valid_out,
    input wire logic [31:0]       dest_word_out,
    input wire logic [31:0]       extension_register_out,
    input var  shu_pkg::shu_cr0_t condition_register_out,
    input var  shu_pkg::shu_xer_t xer_out,
    input wire logic              op_error_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    logic legal;
    assign legal = issue_valid_in && req_in.op <= shu_pkg::SHU_OP_SRLQ;
    issue_answer_a:
        assert property (legal |=> dest_valid_out && !op_error_out) else $error("no answer");
    refused_op_a:
        assert property (issue_valid_in && !legal |=> op_error_out && !dest_valid_out
            && $stable(dest_word_out)) else $error("bad op not refused");
    idle_quiet_a:
        assert property (!issue_valid_in |=> !dest_valid_out && !op_error_out
            && $stable(dest_word_out)) else $error("output without issue");
    xer_copy_a:
        assert property ($past(resetn_in) |-> xer_out == $past(xer_in)) else $error("xer changed");
    cond_hold_a:
        assert property (!(legal && req_in.record_flag) |=> $stable(condition_register_out))
        else $error("cr changed");
    cond_value_a:
        assert property (legal && req_in.record_flag |=> condition_register_out ==
            {dest_word_out[31], !dest_word_out[31] && dest_word_out != 32'h0,
             dest_word_out == 32'h0, $past(xer_in.summary_ovf)}) else $error("cr wrong");
    long_keep_a:
        assert property (legal && req_in.op inside {shu_pkg::SHU_OP_SLLQ, shu_pkg::SHU_OP_SRLQ}
            && !ext_write_in |=> $stable(extension_register_out)) else $error("ext moved");
    plain_zero_a:
        assert property (legal && req_in.amount_operand[5] && req_in.op <= shu_pkg::SHU_OP_SRQ
            |=> dest_word_out == 32'h0) else $error("big shift not zero");
    zero_load_a:
        assert property (legal && req_in.op == shu_pkg::SHU_OP_SLQ
            && req_in.amount_operand[5:0] == 6'h00 |=> extension_register_out ==
            $past(req_in.source_word) && dest_word_out == $past(req_in.source_word))
        else $error("zero shift wrong");
endmodule
bind shu_shift_unit shu_checker u_chk
(
    .mclk_in(mclk_in), .resetn_in(resetn_in), .issue_valid_in(issue_valid_in),
    .req_in(req_in), .xer_in(xer_in), .ext_write_in(ext_write_in),
    .ext_wdata_in(ext_wdata_in), .dest_valid_out(dest_valid_out),
    .dest_word_out(dest_word_out), .extension_register_out(extension_register_out),
    .condition_register_out(condition_register_out), .xer_out(xer_out),
    .op_error_out(op_error_out)
);
`default_nettype wire

// ---- verif/shu_issue_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************
// Decode side issuer
// ****************
module shu_issue_model
(
    input  wire logic              mclk_in,
    output logic                   issue_valid_out,
    output var  shu_pkg::shu_req_t req_out,
    output var  shu_pkg::shu_xer_t xer_out,
    output logic                   ext_write_out,
    output logic [31:0]            ext_wdata_out
);
    shu_pkg::shu_req_t rq[$];
    shu_pkg::shu_xer_t xq[$];
    logic [32:0]       wq[$];
    initial
    begin
        issue_valid_out = 1'b0;
        req_out = '0;
        xer_out = '0;
        ext_write_out = 1'b0;
        ext_wdata_out = '0;
    end
    // A side move rides with the op it was pushed with, never alone
    task automatic push(input shu_pkg::shu_req_t r, input shu_pkg::shu_xer_t x,
                        input logic [32:0] w);
        rq.push_back(r);
        xq.push_back(x);
        wq.push_back(w);
    endtask
    // Idle request flips every cycle so a stale op can never look valid
    always @(posedge mclk_in)
    begin
        if (rq.size() > 0)
        begin
            issue_valid_out <= 1'b1;
            req_out <= rq.pop_front();
            xer_out <= xq.pop_front();
            {ext_write_out, ext_wdata_out} <= wq.pop_front();
        end
        else
        begin
            issue_valid_out <= 1'b0;
            req_out <= ~req_out;
            ext_write_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- verif/test_shu_shift_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_shu_shift_unit;
    logic              mclk_in = 1'b0;
    logic              resetn_in = 1'b0;
    logic              issue_valid;
    logic              dest_valid;
    logic              op_err;
    logic [31:0]       dest_word;
    logic [31:0]       ext_word;
    logic [31:0]       m_dest = 32'h0;
    logic [31:0]       m_ext = 32'h0;
    logic              ext_write;
    logic [31:0]       ext_wdata;
    logic [71:0]       seen_w;
    logic [71:0]       want_w;
    logic [71:0]       expq[$];
    shu_pkg::shu_req_t req;
    shu_pkg::shu_xer_t xer_i;
    shu_pkg::shu_xer_t xer_o;
    shu_pkg::shu_cr0_t cond;
    shu_pkg::shu_cr0_t m_cond = '0;
    int                mismatches = 0;
    int                samples_checked = 0;
    int                cycles = 0;
    always #2 mclk_in = ~mclk_in;
    shu_shift_unit u_dut
    (
        .mclk_in(mclk_in), .resetn_in(resetn_in), .issue_valid_in(issue_valid),
        .req_in(req), .xer_in(xer_i), .ext_write_in(ext_write), .ext_wdata_in(ext_wdata),
        .dest_valid_out(dest_valid), .dest_word_out(dest_word),
        .extension_register_out(ext_word), .condition_register_out(cond),
        .xer_out(xer_o), .op_error_out(op_err)
    );
    shu_issue_model u_part
    (
        .mclk_in(mclk_in), .issue_valid_out(issue_valid), .req_out(req), .xer_out(xer_i),
        .ext_write_out(ext_write), .ext_wdata_out(ext_wdata)
    );
    task automatic check(input logic [71:0] seen, input logic [71:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic issue(input logic [3:0] op, input logic [4:0] n, input logic big);
        shu_pkg::shu_req_t r;
        shu_pkg::shu_xer_t x;
        logic [63:0]       d;
        logic [31:0]       w;
        logic [31:0]       m;
        logic [31:0]       res;
        logic              we;
        logic [31:0]       wd;
        r.op = shu_pkg::shu_op_t'(op);
        r.source_word = $urandom();
        r.amount_operand = $urandom();
        r.amount_operand[5:0] = {big, n};
        r.instr_word = $urandom();
        r.instr_word[15:11] = n;
        r.record_flag = 1'($urandom());
        x = 3'($urandom());
        we = 2'($urandom()) == 2'h0;
        wd = $urandom();
        big = big && !(op inside {[4'h4:4'h7]});
        d = op[0] ? {r.source_word, r.source_word} >> n : {r.source_word, r.source_word} << n;
        w = op[0] ? d[31:0] : d[63:32];
        m = op[0] ? 32'hffff_ffff >> n : 32'hffff_ffff << n;
        if (big && op < 4'h4)
            m = 32'h0;
        if (big && op > 4'h7)
        begin
            m = ~m;
            w = 32'h0;
        end
        res = op > 4'h5 ? (w & m) | (m_ext & ~m) : w & m;
        // Side move lands even on a refused op, but a loading shift beats it
        if (we)
            m_ext = wd;
        if (op > 4'h9)
            expq.push_back({1'b1, m_dest, m_ext, m_cond, x});
        else
        begin
            if (op inside {[4'h2:4'h7]})
                m_ext = w;
            m_dest = res;
            if (r.record_flag)
                m_cond = {res[31], !res[31] && res != 32'h0, res == 32'h0, x.summary_ovf};
            expq.push_back({1'b0, m_dest, m_ext, m_cond, x});
        end
        u_part.push(r, x, {we, wd});
    endtask
    initial
    begin
        void'($urandom(32'hb004));
        repeat (16) @(posedge mclk_in);
        resetn_in <= 1'b1;
        @(posedge mclk_in);
        // Every op at both count extremes and both bit 26 values first
        for (int i = 0; i < 400; i++)
        begin
            if (i < 40)
                issue(4'(i % 10), ((i / 10) % 2) ? 5'h1f : 5'h00, i >= 20);
            else
                issue(4'($urandom_range(0, 12)), 5'($urandom()), 1'($urandom()));
            if (i % 7 == 6)
                repeat (3) @(posedge mclk_in);
        end
        wait (expq.size() == 0);
        repeat (4) @(posedge mclk_in);
        close_out();
    end
    always @(posedge mclk_in)
    begin
        cycles++;
        if (dest_valid === 1'b1 || op_err === 1'b1)
        begin
            seen_w = {op_err, dest_word, ext_word, cond, xer_o};
            want_w = expq.size() > 0 ? expq.pop_front() : '1;
            check(seen_w, want_w);
        end
        if (cycles == 5000)
        begin
            mismatches++;
            close_out();
        end
    end
endmodule
`default_nettype wire
